// ===== hw/aic_aux_irq_ctrl.sv
// Auxiliary interrupt controller top: masks, status, index, swap reads
`timescale 1ns/10ps
`include "aic_consts.svh"
module aic_aux_irq_ctrl
  import aic_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input aic_sfr_req_t i_sfr,
  input aic_src_t i_src,
  input wire logic i_aux_global_enable,
  output aic_sfr_rsp_t o_sfr,
  output logic o_aux_irq,
  output logic [15:0] o_vector_addr,
  output logic [3:0] o_pending_code,
  output logic [7:0] o_flags,
  output logic o_conv_result_hold,
  output logic o_read_swap_select
);

  // ******************************************************************
  // Local state
  // ******************************************************************
  typedef struct packed {
    logic [7:0] mask;
    logic read_swap_select;
    logic [7:0] live;
    logic [7:0] flags;
    logic [3:0] code;
    logic irq;
    logic [7:0] rdata;
    logic hit;
    logic ack;
  } aic_ctrl_st_t;

  aic_ctrl_st_t st;
  aic_ctrl_st_t next_st;

  logic acc_pend;
  logic conv_pend;
  logic acc_lsb_read;
  logic conv_lsb_read;
  logic [7:0] live_now;
  logic [7:0] flags_now;
  aic_code_t code_now;

  // ******************************************************************
  // Address decode helpers
  // ******************************************************************

  // True when the bus address lands on one of the four owned registers
  function automatic logic owns(input logic [7:0] a);
    return (a == `AIC_ADDR_POLL) || (a == `AIC_ADDR_PEND) ||
           (a == `AIC_ADDR_MASK) || (a == `AIC_ADDR_FLAGS);
  endfunction : owns

  // Read mux; the swap select decides which address shows what
  function automatic logic [7:0] read_word(
    input logic [7:0] a,
    input logic sel,
    input logic [7:0] mask,
    input logic [7:0] live,
    input logic [7:0] flags,
    input logic [3:0] code
  );
    logic [7:0] d;
    d = 8'h00;
    unique case (a)
      `AIC_ADDR_POLL: begin
        d = sel ? live : mask;
      end
      `AIC_ADDR_MASK: begin
        d = sel ? mask : live;
      end
      `AIC_ADDR_PEND: begin
        d = {4'h0, code};
      end
      `AIC_ADDR_FLAGS: begin
        d = flags;
      end
      default: begin
        d = 8'h00;
      end
    endcase
    return d;
  endfunction : read_word

  // ******************************************************************
  // Held events for the accumulator and the converter
  // ******************************************************************

  // Reads of the result low bytes are snooped here; the bytes live elsewhere
  assign acc_lsb_read = i_sfr.rd && (i_sfr.addr == `AIC_ADDR_ACC_LSB);
  assign conv_lsb_read = i_sfr.rd && (i_sfr.addr == `AIC_ADDR_CONV_LSB);

  // Accumulator event held until its low byte is read
  aic_event_latch u_acc_latch (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_set(i_src.acc_done),
    .i_clear(acc_lsb_read),
    .o_pend(acc_pend)
  );

  // Conversion event held until its low byte is read
  aic_event_latch u_conv_latch (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_set(i_src.conv_done),
    .i_clear(conv_lsb_read),
    .o_pend(conv_pend)
  );

  // ******************************************************************
  // Raw source vector
  // ******************************************************************

  // Sources come from same-clock peripherals, so no synchroniser here
  always_comb begin
    live_now = 8'h00;
    live_now[`AIC_BIT_ONE_HZ] = i_src.one_hz;
    live_now[`AIC_BIT_ACC] = acc_pend;
    live_now[`AIC_BIT_CONV] = conv_pend;
    live_now[`AIC_BIT_KHZ] = i_src.khz_tick;
    live_now[`AIC_BIT_SER_TX] = i_src.ser_tx;
    live_now[`AIC_BIT_SER_RX] = i_src.ser_rx | i_src.twowire;
    live_now[`AIC_BIT_ANA_UV] = i_src.ana_uv;
    live_now[`AIC_BIT_DIG_UV] = i_src.dig_uv | i_src.brk;
  end

  // Masked status, from the registered live levels and masks
  assign flags_now = st.live & st.mask;

  // ******************************************************************
  // Priority encoding
  // ******************************************************************

  // Bit 0 outranks bit 7; the seconds timer is served last
  aic_prio_enc u_prio (
    .i_flags(flags_now),
    .o_code(code_now)
  );

  // ******************************************************************
  // Next state
  // ******************************************************************

  // Register writes, status capture and the registered read answer
  always_comb begin
    next_st = st;
    next_st.live = live_now;
    next_st.flags = flags_now;
    next_st.code = code_now;
    // Request is registered with status on the same edge; the core samples it late anyway
    next_st.irq = (|flags_now) && i_aux_global_enable;
    next_st.ack = 1'b0;
    next_st.hit = 1'b0;
    next_st.rdata = st.rdata;
    if (i_sfr.wr) begin
      if (i_sfr.addr == `AIC_ADDR_MASK) begin
        next_st.mask = i_sfr.wdata;
      end
      if (i_sfr.addr == `AIC_ADDR_POLL) begin
        // Only bit 0 is kept; the mask view there is read-only
        next_st.read_swap_select = i_sfr.wdata[`AIC_BIT_READ_SWAP];
      end
      next_st.hit = owns(i_sfr.addr);
      next_st.ack = owns(i_sfr.addr);
    end else if (i_sfr.rd) begin
      // Unowned addresses answer zero with hit low so another block may drive
      next_st.rdata = read_word(i_sfr.addr, st.read_swap_select, st.mask,
                                st.live, st.flags, st.code);
      next_st.hit = owns(i_sfr.addr);
      next_st.ack = owns(i_sfr.addr);
    end
  end

  // ******************************************************************
  // State register
  // ******************************************************************

  // Synchronous reset; all fields start at their documented zeros
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st.mask <= `AIC_RST_MASK;
      st.read_swap_select <= 1'b0;
      st.live <= 8'h00;
      st.flags <= `AIC_RST_FLAGS;
      st.code <= 4'h0;
      st.irq <= 1'b0;
      st.rdata <= 8'h00;
      st.hit <= 1'b0;
      st.ack <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ******************************************************************
  // Outputs
  // ******************************************************************

  // Bus answer, one cycle after the strobe
  assign o_sfr.rdata = st.rdata;
  assign o_sfr.hit = st.hit;
  assign o_sfr.ack = st.ack;

  // Combined request and the shared entry point
  assign o_aux_irq = st.irq;
  assign o_vector_addr = `AIC_SHARED_VECTOR;

  // Status views for the core and for debug
  assign o_pending_code = st.code;
  assign o_flags = st.flags;
  assign o_read_swap_select = st.read_swap_select;

  // Converter stalls result updates while its event is held
  assign o_conv_result_hold = conv_pend;

endmodule : aic_aux_irq_ctrl

// ===== hw/aic_event_latch.sv
// Sticky event holder that a bus read retires
`timescale 1ns/10ps
module aic_event_latch
  import aic_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_set,
  input wire logic i_clear,
  output logic o_pend
);

  typedef struct packed {
    logic pend;
  } aic_latch_st_t;

  aic_latch_st_t st;
  aic_latch_st_t next_st;

  // Set beats clear so an event landing on the retiring read survives
  always_comb begin
    next_st = st;
    if (i_set) begin
      next_st.pend = 1'b1;
    end else if (i_clear) begin
      next_st.pend = 1'b0;
    end
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_pend = st.pend;

endmodule : aic_event_latch

// ===== hw/aic_prio_enc.sv
// Fixed priority encoder from flag vector to pending code
`timescale 1ns/10ps
module aic_prio_enc
  import aic_pkg::*;
(
  input wire logic [7:0] i_flags,
  output aic_code_t o_code
);

  // Lowest bit wins; code is bit position plus one
  function automatic aic_code_t pick(input logic [7:0] f);
    aic_code_t c;
    c = AIC_CODE_NONE;
    for (int i = 7; i >= 0; i--) begin
      if (f[i]) begin
        c = aic_code_t'(4'(i + 1));
      end
    end
    return c;
  endfunction : pick

  assign o_code = pick(i_flags);

endmodule : aic_prio_enc

// ===== inc/aic_consts.svh
// Constant macros for the auxiliary interrupt controller
`ifndef AIC_CONSTS_SVH
`define AIC_CONSTS_SVH

// ******************************************************************
// Register offsets on the special function register bus
// ******************************************************************
`define AIC_ADDR_POLL 8'hA4
`define AIC_ADDR_PEND 8'hA5
`define AIC_ADDR_MASK 8'hA6
`define AIC_ADDR_FLAGS 8'hA7
// Result low bytes whose read retires the held events
`define AIC_ADDR_ACC_LSB 8'hC1
`define AIC_ADDR_CONV_LSB 8'hD9

// ******************************************************************
// Field positions, source order bit 7 down to bit 0
// ******************************************************************
`define AIC_BIT_ONE_HZ 3'h7
`define AIC_BIT_ACC 3'h6
`define AIC_BIT_CONV 3'h5
`define AIC_BIT_KHZ 3'h4
`define AIC_BIT_SER_TX 3'h3
`define AIC_BIT_SER_RX 3'h2
`define AIC_BIT_ANA_UV 3'h1
`define AIC_BIT_DIG_UV 3'h0
`define AIC_BIT_READ_SWAP 3'h0
`define AIC_PEND_MSB 3'h3

// ******************************************************************
// Reset values and fixed figures
// ******************************************************************
`define AIC_RST_POLL 8'h00
`define AIC_RST_PEND 8'h00
`define AIC_RST_MASK 8'h00
`define AIC_RST_FLAGS 8'h00
`define AIC_SHARED_VECTOR 16'h0033
`define AIC_READ_LATENCY 2'h1

`endif

// ===== inc/aic_pkg.sv
// Types shared by the auxiliary interrupt controller files
package aic_pkg;

  // ******************************************************************
  // Pending index codes
  // ******************************************************************
  typedef enum logic [3:0] {
    AIC_CODE_NONE = 4'b0000,
    AIC_CODE_DIG_UV = 4'b0001,
    AIC_CODE_ANA_UV = 4'b0010,
    AIC_CODE_SER_RX = 4'b0011,
    AIC_CODE_SER_TX = 4'b0100,
    AIC_CODE_KHZ = 4'b0101,
    AIC_CODE_CONV = 4'b0110,
    AIC_CODE_ACC = 4'b0111,
    AIC_CODE_ONE_HZ = 4'b1000
  } aic_code_t;

  // ******************************************************************
  // Bus and source carriers
  // ******************************************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } aic_sfr_req_t;

  typedef struct packed {
    logic [7:0] rdata;
    logic hit;
    logic ack;
  } aic_sfr_rsp_t;

  typedef struct packed {
    logic one_hz;
    logic acc_done;
    logic conv_done;
    logic khz_tick;
    logic ser_tx;
    logic ser_rx;
    logic twowire;
    logic ana_uv;
    logic dig_uv;
    logic brk;
  } aic_src_t;

endpackage : aic_pkg

// ===== verif/aic_aux_irq_ctrl_bench.sv
// Self-checking bench for the auxiliary interrupt controller
`timescale 1ns/10ps
`include "aic_consts.svh"
module aic_aux_irq_ctrl_bench
  import aic_pkg::*;
;
  logic i_clk;
  logic i_srst;
  logic ge;
  aic_src_t src;
  aic_sfr_req_t req;
  aic_sfr_rsp_t rsp;
  logic irq;
  logic hold;
  logic swap;
  logic [15:0] vec;
  logic [3:0] code;
  logic [7:0] flags;
  logic [7:0] rd_val;
  int n_errors;
  int checked;

  aic_aux_irq_ctrl aic_aux_irq_ctrl_inst (.i_clk(i_clk), .i_srst(i_srst), .i_sfr(req),
    .i_src(src), .i_aux_global_enable(ge), .o_sfr(rsp), .o_aux_irq(irq),
    .o_vector_addr(vec), .o_pending_code(code), .o_flags(flags),
    .o_conv_result_hold(hold), .o_read_swap_select(swap));
  aic_core_model aic_core_model_inst (.i_clk(i_clk), .i_rsp(rsp), .o_req(req));

  // ******************************
  // Clock, helpers and sequence
  // ******************************
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  task automatic chk(input logic [15:0] exp, input logic [15:0] act);
    checked++;
    if (act !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, act);
    end
  endtask : chk

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    aic_core_model_inst.access(a, 8'h00, 1'b0, rd_val);
    chk({8'h00, e}, {8'h00, rd_val});
  endtask : rchk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    aic_core_model_inst.access(a, d, 1'b1, rd_val);
  endtask : wr

  // Two-cycle source-to-output latency plus margin (three cycles for held events), then sample mid-cycle
  task automatic settle();
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
  endtask : settle

  task automatic put_src(input logic [7:0] v, input logic tw, input logic bk);
    @(posedge i_clk);
    src <= '{v[7], v[6], v[5], v[4], v[3], v[2], tw, v[1], v[0], bk};
    settle();
  endtask : put_src

  task automatic close_out();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out

  // Watchdog well beyond the fewer than two hundred cycles the sequence needs
  initial begin
    repeat (4000) @(posedge i_clk);
    n_errors++;
    close_out();
  end

  initial begin
    n_errors = 0;
    checked = 0;
    i_srst = 1'b1;
    ge = 1'b0;
    src = '0;
    repeat (3) @(posedge i_clk);
    i_srst <= 1'b0;
    rchk(`AIC_ADDR_POLL, 8'h00);
    rchk(`AIC_ADDR_PEND, 8'h00);
    rchk(`AIC_ADDR_MASK, 8'h00);
    rchk(`AIC_ADDR_FLAGS, 8'h00);
    rchk(8'h80, 8'h00);
    chk(16'h0033, vec);
    wr(`AIC_ADDR_MASK, 8'hFF);
    put_src(8'h9B, 1'b0, 1'b0);
    rchk(`AIC_ADDR_POLL, 8'hFF);
    rchk(`AIC_ADDR_MASK, 8'h9B);
    wr(`AIC_ADDR_POLL, 8'h01);
    chk(16'h0001, {15'h0000, swap});
    rchk(`AIC_ADDR_POLL, 8'h9B);
    rchk(`AIC_ADDR_MASK, 8'hFF);
    wr(`AIC_ADDR_POLL, 8'hFE);
    rchk(`AIC_ADDR_POLL, 8'hFF);
    wr(`AIC_ADDR_MASK, 8'h92);
    settle();
    chk(16'h0092, {8'h00, flags});
    chk(16'h0002, {12'h000, code});
    chk(16'h0000, {15'h0000, irq});
    @(posedge i_clk);
    ge <= 1'b1;
    settle();
    chk(16'h0001, {15'h0000, irq});
    wr(`AIC_ADDR_MASK, 8'hFF);
    // Walk downward so each new source outranks any held event
    for (int i = 7; i >= 0; i--) begin
      put_src(8'h01 << i, 1'b0, 1'b0);
      chk(16'h0001, {15'h0000, flags[i]});
      chk(16'(i + 1), {12'h000, code});
    end
    put_src(8'h00, 1'b0, 1'b0);
    chk(16'h0060, {8'h00, flags});
    chk(16'h0006, {12'h000, code});
    chk(16'h0001, {15'h0000, hold});
    rchk(`AIC_ADDR_CONV_LSB, 8'h00);
    settle();
    chk(16'h0040, {8'h00, flags});
    chk(16'h0000, {15'h0000, hold});
    rchk(`AIC_ADDR_ACC_LSB, 8'h00);
    settle();
    chk(16'h0000, {8'h00, flags});
    chk(16'h0000, {12'h000, code});
    put_src(8'h00, 1'b1, 1'b0);
    chk(16'h0004, {8'h00, flags});
    put_src(8'h00, 1'b0, 1'b1);
    chk(16'h0001, {8'h00, flags});
    close_out();
  end
endmodule : aic_aux_irq_ctrl_bench

// ===== verif/aic_aux_irq_ctrl_sva.sv
// Port-level assertion checker for the auxiliary interrupt controller
`timescale 1ns/10ps
`include "aic_consts.svh"
module aic_aux_irq_ctrl_chk
  import aic_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input aic_sfr_req_t i_sfr,
  input aic_src_t i_src,
  input wire logic i_aux_global_enable,
  input aic_sfr_rsp_t o_sfr,
  input wire logic o_aux_irq,
  input wire logic [15:0] o_vector_addr,
  input wire logic [3:0] o_pending_code,
  input wire logic [7:0] o_flags,
  input wire logic o_conv_result_hold,
  input wire logic o_read_swap_select
);
  // ******************************
  // Decode helpers and properties
  // ******************************
  // Owned window is the four offsets from poll up to flags
  logic own;
  logic rd_only;
  assign own = (i_sfr.addr >= `AIC_ADDR_POLL) && (i_sfr.addr <= `AIC_ADDR_FLAGS);
  assign rd_only = i_sfr.rd && !i_sfr.wr;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  AST_VECTOR: assert property (o_vector_addr == 16'h0033) else $error("vector moved");
  AST_IRQ: assert property (o_aux_irq == ((|o_flags) && $past(i_aux_global_enable)))
    else $error("request does not follow flags and global enable");
  AST_CODE_NONE: assert property ((o_flags == 8'h00) |-> (o_pending_code == 4'h0))
    else $error("code without flags");
  AST_CODE_TOP: assert property (o_flags[0] |-> (o_pending_code == 4'h1))
    else $error("bit 0 not winning");
  AST_CODE_LOW: assert property ((o_flags == 8'h80) |-> (o_pending_code == 4'h8))
    else $error("seconds code wrong");
  AST_ACK: assert property ((i_sfr.wr || i_sfr.rd) && own |=> o_sfr.ack && o_sfr.hit)
    else $error("owned access not answered");
  AST_UNMAPPED: assert property (rd_only && !own |=> !o_sfr.hit && (o_sfr.rdata == 8'h00))
    else $error("unowned read answered");
  // Read data is the status that stood at the taking edge, not the one after it
  AST_FLAGS_RD: assert property (rd_only && (i_sfr.addr == `AIC_ADDR_FLAGS) |=>
    o_sfr.rdata == $past(o_flags)) else $error("flags read mismatch");
  AST_SWAP: assert property (i_sfr.wr && (i_sfr.addr == `AIC_ADDR_POLL) |=>
    o_read_swap_select == $past(i_sfr.wdata[0])) else $error("swap select not stored");
  AST_HOLD: assert property (i_src.conv_done |=> o_conv_result_hold)
    else $error("result hold not raised");
  AST_CONV_CLR: assert property (rd_only && (i_sfr.addr == `AIC_ADDR_CONV_LSB) &&
    !i_src.conv_done |=> !o_conv_result_hold) else $error("conversion event not retired");
  // Main scenarios reached
  cover property (o_aux_irq);
  cover property (o_pending_code == 4'h8);
  cover property (o_conv_result_hold ##1 !o_conv_result_hold);
endmodule : aic_aux_irq_ctrl_chk

bind aic_aux_irq_ctrl aic_aux_irq_ctrl_chk aic_aux_irq_ctrl_chk_inst (.i_clk(i_clk),
  .i_srst(i_srst), .i_sfr(i_sfr), .i_src(i_src), .i_aux_global_enable(i_aux_global_enable),
  .o_sfr(o_sfr), .o_aux_irq(o_aux_irq), .o_vector_addr(o_vector_addr),
  .o_pending_code(o_pending_code), .o_flags(o_flags),
  .o_conv_result_hold(o_conv_result_hold), .o_read_swap_select(o_read_swap_select));

// ===== verif/aic_core_model.sv
// Core-side model issuing special function register accesses
`timescale 1ns/10ps
module aic_core_model
  import aic_pkg::*;
(
  input wire logic i_clk,
  input aic_sfr_rsp_t i_rsp,
  output aic_sfr_req_t o_req
);
  // ******************************
  // Access sequencing
  // ******************************
  initial o_req = '0;
  // One-cycle strobe; idle lines show inverted values so stale data never looks valid
  task automatic access(input logic [7:0] addr, input logic [7:0] data, input logic wr,
                        output logic [7:0] rdata);
    @(posedge i_clk);
    o_req <= '{addr, data, wr, !wr};
    @(posedge i_clk);
    o_req <= '{~addr, ~data, 1'b0, 1'b0};
    @(posedge i_clk);
    rdata = i_rsp.rdata;
  endtask : access
endmodule : aic_core_model
